// ===== core/iop_consts.vh
// constants for the i/o port and clock block unit
`ifndef IOP_CONSTS_VH
`define IOP_CONSTS_VH

// ============================================================
// address map (byte address = region * 0x100 + slot * 0x20 + reg * 4)
`define IOP_RGN_PORT    4'h0
`define IOP_RGN_CLK     4'h1
`define IOP_REG_CTRL    3'h0
`define IOP_REG_DATA    3'h1
`define IOP_REG_CMP     3'h2
`define IOP_REG_TIME    3'h3
`define IOP_REG_COUNT   3'h4
`define IOP_REG_TSTAMP  3'h5
`define IOP_REG_STAT    3'h6

// ============================================================
// port control fields
`define IOP_C_EN        0
`define IOP_C_OUT       1
`define IOP_C_OD        2
`define IOP_C_COND      3
`define IOP_C_NEQ       4
`define IOP_C_TIMED     5
`define IOP_C_STBIN     6
`define IOP_C_STBOUT    7
`define IOP_C_CLK_LO    8
`define IOP_C_CLK_HI    10
`define IOP_CTRL_RST    32'h0000_0000

// ============================================================
// clock block control fields
`define IOP_CB_SRCPIN   0
`define IOP_CB_PINSEL   1
`define IOP_CB_DIV_LO   8
`define IOP_CB_DIV_HI   15
`define IOP_CB_RST      32'h0000_0000

// ============================================================
// port widths and pin bases
`define IOP_W_P0        1
`define IOP_W_P1        1
`define IOP_W_P2        4
`define IOP_W_P3        8
`define IOP_W_P4        16
`define IOP_W_P5        32
`define IOP_B_P1        1
`define IOP_XFER_W      32
`define IOP_CNT_W       16

`endif

// ===== core/iop_top.v
// i/o ports with serialisers, port counters, pin sharing and clock blocks behind an apb slave
//
// Function
// R1: ports of width 1, 4, 8, 16 and 32 bits, each mapped to pins.
// R2: ports drive pins high or low, or sample them, optionally waiting on a condition.
// R3: every core access to a port completes within one cycle.
// R4: open-drain mode per port: zero pulls low, one releases the pin.
// R5: data passes through a serialiser and transfer register, words wider than port.
// R6: each port has a 16-bit counter that can schedule a transfer.
// R7: the port counter is readable at any time and delays transfers.
// R8: each transfer captures the counter value as a timestamp.
// R9: an enabled link disconnects every port from its pins; the code only blocks port drive on the LINK_MASK pins, not sampling.
// R10: an enabled narrower port owns pins shared with a wider port.
// R11: unshared pins of a wider port stay usable by it.
// R12: a port always transfers at its nominal width.
// R13: six clock blocks; block 0 is the fixed tile reference clock.
// R14: blocks other than 0 are programmable to other rates.
// R15: a clock block can take its clock from a 1-bit port pin.
// R16: a pin clock may be divided before use.
// R17: ports accept an incoming strobe and generate an outgoing strobe.
// R18: after reset every port uses clock block 0.
// R19: pin events are signalled directly to the scheduler.
// R20: while reset is held low all pins enable their pull-downs.
// R21: a conditional input waits for pins equal or unequal to a compare value.
// R22: a disabled port neither drives nor claims its pins.
`timescale 1ns/1ps
`include "iop_consts.vh"

module iop_top #(
  parameter NPIN      = 32,
  parameter NPORT     = 6,
  parameter NCLK      = 6,
  parameter LINK_MASK = 32'hF000_0000
) (
  // clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // apb slave
  input  wire [11:0]       paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  // pins
  input  wire [NPIN-1:0]   pin_in,
  output wire [NPIN-1:0]   pin_out,
  output wire [NPIN-1:0]   pin_oe,
  output wire [NPIN-1:0]   pin_pd_en,
  // link mux and strobes
  input  wire              link_en,
  input  wire [NPORT-1:0]  strobe_in,
  output wire [NPORT-1:0]  strobe_out,
  // scheduler events
  output wire [NPORT-1:0]  port_event
);

  // ==========================================================
  // port geometry
  function integer pw;
    input integer k;
    begin
      case (k)
        0:       pw = `IOP_W_P0;                                            // R1
        1:       pw = `IOP_W_P1;
        2:       pw = `IOP_W_P2;
        3:       pw = `IOP_W_P3;
        4:       pw = `IOP_W_P4;
        default: pw = `IOP_W_P5;
      endcase
    end
  endfunction

  // narrow ports overlay the low pins of the wide ones
  function integer pbase;
    input integer k;
    begin
      pbase = (k == 1) ? `IOP_B_P1 : 0;
    end
  endfunction

  function [31:0] pmask;
    input integer k;
    begin
      pmask = (pw(k) == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << pw(k)) - 32'h0000_0001);
    end
  endfunction

  // slices per word at the nominal width, cut to the slice counter's size
  function [5:0] nslice;
    input integer k;
    integer quot;
    begin
      quot   = 32 / pw(k);
      nslice = quot[5:0];
    end
  endfunction

  // ==========================================================
  // state
  reg [NPIN-1:0]  pin_s1_r, pin_s2_r;
  reg [NPORT-1:0] stb_s1_r, stb_s2_r;
  reg [NPIN-1:0]  pin_out_r, pin_oe_r;
  reg [31:0]      prdata_r;
  reg [31:0]      ctrl_r  [0:NPORT-1];
  reg [31:0]      xfer_r  [0:NPORT-1];
  reg [31:0]      sh_r    [0:NPORT-1];
  reg [31:0]      oval_r  [0:NPORT-1];
  reg [31:0]      cmp_r   [0:NPORT-1];
  reg [15:0]      time_r  [0:NPORT-1];
  reg [15:0]      cnt_r   [0:NPORT-1];
  reg [15:0]      ts_r    [0:NPORT-1];
  reg [5:0]       scnt_r  [0:NPORT-1];
  reg [NPORT-1:0] xfull_r, busy_r, evt_r, sout_r;
  reg [31:0]      cb_ctrl_r [0:NCLK-1];
  reg [7:0]       cb_cnt_r  [0:NCLK-1];
  reg [NCLK-1:0]  cb_prev_r;

  reg [NCLK-1:0]  cb_edge, cb_tick;
  reg [NPORT-1:0] ptick, start, samp;
  reg [31:0]      pval [0:NPORT-1];
  reg [NPIN-1:0]  pin_out_nxt, pin_oe_nxt;
  reg [31:0]      rd_nxt;
  reg             hit;
  integer         k, m, n, p, q, s, c; // one loop index per process, so no @* block wakes another

  wire       setup_ph = psel & ~penable;
  wire       acc_ph   = psel & penable;
  wire [2:0] slot     = paddr[7:5];
  wire [2:0] rsel     = paddr[4:2];
  wire [2:0] cbsel    = paddr[4:2];
  wire       port_rg  = (paddr[11:8] == `IOP_RGN_PORT) && (slot < NPORT);
  wire       cb_rg    = (paddr[11:8] == `IOP_RGN_CLK) && (paddr[7:5] == 3'h0) && (cbsel < NCLK);

  // ==========================================================
  // clock block ticks: ref is every pclk, a pin source ticks on its synced rising edge
  always @*
  begin
    for (m = 0; m < NCLK; m = m + 1)
    begin
      if (m == 0)
        cb_edge[m] = 1'b1;                                                  // R13
      else if (cb_ctrl_r[m][`IOP_CB_SRCPIN])                                // R15
        cb_edge[m] = (cb_ctrl_r[m][`IOP_CB_PINSEL] ? pin_s2_r[`IOP_B_P1] : pin_s2_r[0]) & ~cb_prev_r[m];
      else
        cb_edge[m] = 1'b1;
      // divide by div+1; zero means undivided
      cb_tick[m] = cb_edge[m] & ((m == 0) || (cb_cnt_r[m] == cb_ctrl_r[m][`IOP_CB_DIV_HI:`IOP_CB_DIV_LO])); // R14 R16
    end
  end

  // ==========================================================
  // per-port sample values, start and sample decisions
  always @*
  begin
    for (n = 0; n < NPORT; n = n + 1)
    begin
      ptick[n] = cb_tick[ctrl_r[n][`IOP_C_CLK_HI:`IOP_C_CLK_LO]] & ctrl_r[n][`IOP_C_EN];
      // always the nominal width, even where a narrower port owns some pins
      pval[n]  = (pin_s2_r >> pbase(n)) & pmask(n);                         // R12
      start[n] = (~ctrl_r[n][`IOP_C_TIMED] | (cnt_r[n] == time_r[n])) &     // R6 R7
                 (~ctrl_r[n][`IOP_C_COND] |
                  ((pval[n] == (cmp_r[n] & pmask(n))) ^ ctrl_r[n][`IOP_C_NEQ])); // R21 R2
      samp[n]  = ptick[n] & ~ctrl_r[n][`IOP_C_OUT] &
                 (~ctrl_r[n][`IOP_C_STBIN] | stb_s2_r[n]) & (busy_r[n] | start[n]); // R17
    end
  end

  // ==========================================================
  // pin ownership: narrowest enabled port wins, link takes priority over all
  always @*
  begin
    pin_out_nxt = {NPIN{1'b0}};
    pin_oe_nxt  = {NPIN{1'b0}};
    for (p = 0; p < NPIN; p = p + 1)
    begin
      s = NPORT;
      for (q = NPORT - 1; q >= 0; q = q - 1)
        if (ctrl_r[q][`IOP_C_EN] && p >= pbase(q) && p < pbase(q) + pw(q)) // R22
          s = q;                                                            // R10 R11
      if (link_en && LINK_MASK[p])                                          // R9
        s = NPORT;
      if (s < NPORT && ctrl_r[s][`IOP_C_OUT])
      begin
        if (ctrl_r[s][`IOP_C_OD])                                           // R4
        begin
          pin_out_nxt[p] = 1'b0;
          pin_oe_nxt[p]  = ~oval_r[s][p - pbase(s)];
        end
        else
        begin
          pin_out_nxt[p] = oval_r[s][p - pbase(s)];                         // R2
          pin_oe_nxt[p]  = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // read mux, evaluated in the setup phase so data comes from a flop
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    hit    = port_rg | cb_rg;
    if (port_rg)
      case (rsel)
        `IOP_REG_CTRL:   rd_nxt = ctrl_r[slot];
        `IOP_REG_DATA:   rd_nxt = xfer_r[slot];
        `IOP_REG_CMP:    rd_nxt = cmp_r[slot];
        `IOP_REG_TIME:   rd_nxt = {16'h0000, time_r[slot]};
        `IOP_REG_COUNT:  rd_nxt = {16'h0000, cnt_r[slot]};                 // R7
        `IOP_REG_TSTAMP: rd_nxt = {16'h0000, ts_r[slot]};                  // R8
        `IOP_REG_STAT:   rd_nxt = {30'h0000_0000, busy_r[slot], xfull_r[slot]};
        default:         hit    = 1'b0;
      endcase
    else if (cb_rg)
      rd_nxt = cb_ctrl_r[cbsel];
  end

  // ==========================================================
  // synchronisers, pin registers and read data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r  <= {NPIN{1'b0}};
      pin_s2_r  <= {NPIN{1'b0}};
      stb_s1_r  <= {NPORT{1'b0}};
      stb_s2_r  <= {NPORT{1'b0}};
      pin_out_r <= {NPIN{1'b0}};
      pin_oe_r  <= {NPIN{1'b0}};
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pin_s1_r  <= pin_in;
      pin_s2_r  <= pin_s1_r;
      stb_s1_r  <= strobe_in;
      stb_s2_r  <= stb_s1_r;
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      if (setup_ph)
        prdata_r <= rd_nxt;
    end
  end

  // ==========================================================
  // clock block registers and dividers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cb_prev_r <= {NCLK{1'b0}};
      for (c = 0; c < NCLK; c = c + 1)
      begin
        cb_ctrl_r[c] <= `IOP_CB_RST;
        cb_cnt_r[c]  <= 8'h00;
      end
    end
    else
    begin
      for (c = 0; c < NCLK; c = c + 1)
      begin
        cb_prev_r[c] <= cb_ctrl_r[c][`IOP_CB_PINSEL] ? pin_s2_r[`IOP_B_P1] : pin_s2_r[0];
        if (cb_tick[c])
          cb_cnt_r[c] <= 8'h00;
        else if (cb_edge[c])
          cb_cnt_r[c] <= cb_cnt_r[c] + 8'h01;
      end
      // block 0 stays on the reference clock, so its control is not writable
      if (acc_ph && pwrite && cb_rg && cbsel != 3'h0)                      // R13 R14
        cb_ctrl_r[cbsel] <= pwdata;
    end
  end

  // ==========================================================
  // port engines: counter, serialiser, transfer register, timestamp
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xfull_r <= {NPORT{1'b0}};
      busy_r  <= {NPORT{1'b0}};
      evt_r   <= {NPORT{1'b0}};
      sout_r  <= {NPORT{1'b0}};
      for (k = 0; k < NPORT; k = k + 1)
      begin
        ctrl_r[k] <= `IOP_CTRL_RST;                                         // R18
        xfer_r[k] <= 32'h0000_0000;
        sh_r[k]   <= 32'h0000_0000;
        oval_r[k] <= 32'h0000_0000;
        cmp_r[k]  <= 32'h0000_0000;
        time_r[k] <= 16'h0000;
        cnt_r[k]  <= 16'h0000;
        ts_r[k]   <= 16'h0000;
        scnt_r[k] <= 6'h00;
      end
    end
    else
    begin
      evt_r <= {NPORT{1'b0}};
      // register writes and data pops come first so engine sets win
      if (acc_ph && port_rg)
      begin
        if (pwrite)
          case (rsel)
            `IOP_REG_CTRL: ctrl_r[slot] <= pwdata;
            `IOP_REG_DATA:
            begin
              xfer_r[slot]  <= pwdata;                                      // R5
              xfull_r[slot] <= 1'b1;
            end
            `IOP_REG_CMP:  cmp_r[slot]  <= pwdata;
            `IOP_REG_TIME: time_r[slot] <= pwdata[15:0];
            default:       ;
          endcase
        else if (rsel == `IOP_REG_DATA && !ctrl_r[slot][`IOP_C_OUT])
          xfull_r[slot] <= 1'b0;
      end
      for (k = 0; k < NPORT; k = k + 1)
      begin
        if (ptick[k])
          cnt_r[k] <= cnt_r[k] + 16'h0001;                                  // R6
        if (ctrl_r[k][`IOP_C_OUT])
        begin
          if (ptick[k])
          begin
            sout_r[k] <= busy_r[k] & ctrl_r[k][`IOP_C_STBOUT];              // R17
            if (busy_r[k])
            begin
              oval_r[k] <= sh_r[k] & pmask(k);
              sh_r[k]   <= sh_r[k] >> pw(k);                                // R5 R12
              scnt_r[k] <= scnt_r[k] - 6'h01;
              if (scnt_r[k] == 6'h01)
                busy_r[k] <= 1'b0;
            end
            else if (xfull_r[k] && start[k])
            begin
              sh_r[k]    <= xfer_r[k];
              scnt_r[k]  <= nslice(k);
              busy_r[k]  <= 1'b1;
              ts_r[k]    <= cnt_r[k];                                       // R8
              evt_r[k]   <= 1'b1;                                           // R19
              if (!(acc_ph && pwrite && port_rg && slot == k && rsel == `IOP_REG_DATA))
                xfull_r[k] <= 1'b0;
            end
          end
        end
        else
        begin
          sout_r[k] <= 1'b0;
          if (samp[k])
          begin
            sh_r[k] <= (sh_r[k] >> pw(k)) | (pval[k] << (32 - pw(k)));      // R5
            if (!busy_r[k])
              ts_r[k] <= cnt_r[k];                                          // R8
            if (busy_r[k] ? (scnt_r[k] == 6'h01) : (pw(k) == 32))
            begin
              xfer_r[k]  <= (sh_r[k] >> pw(k)) | (pval[k] << (32 - pw(k)));
              xfull_r[k] <= 1'b1;
              busy_r[k]  <= 1'b0;
              evt_r[k]   <= 1'b1;                                           // R19 R2
            end
            else
            begin
              busy_r[k] <= 1'b1;
              scnt_r[k] <= busy_r[k] ? (scnt_r[k] - 6'h01) : (nslice(k) - 6'h01);
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // outputs; zero wait states keeps every core access to one cycle
  assign pready     = 1'b1;                                                 // R3
  assign pslverr    = acc_ph & ~hit;
  assign prdata     = prdata_r;
  assign pin_out    = pin_out_r;
  assign pin_oe     = pin_oe_r & {NPIN{presetn}};
  assign pin_pd_en  = {NPIN{~presetn}};                                     // R20
  assign strobe_out = sout_r;
  assign port_event = evt_r;

endmodule // iop_top

// ===== verif/iop_ext_hw.sv
// pin-side hardware model: board pull-ups, bench-driven data and strobes
`timescale 1ns/1ps
module iop_ext_hw (
  // clock
  input  wire        pclk,
  // device pins
  input  wire [31:0] pin_out,
  input  wire [31:0] pin_oe,
  output wire [31:0] pin_in,
  // bench requests
  input  wire [31:0] ext_val,
  input  wire [31:0] ext_en,
  input  wire [5:0]  stb_req,
  output reg  [5:0]  strobe_in = 6'h00
);
  // ============================================================
  // wire level: device drive wins, then our driver, else the board pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);

  // strobe moves only after an edge, once the data beside it is settled
  always @(posedge pclk)
    strobe_in <= stb_req;
endmodule // iop_ext_hw

// ===== verif/iop_top_asserts.sv
// concurrent checks on the port unit's bus, pin and event ports
`timescale 1ns/1ps
module iop_chk #(
  parameter NPIN      = 32,
  parameter NPORT     = 6,
  parameter NCLK      = 6,
  parameter LINK_MASK = 32'hF000_0000
) (
  // clock and reset
  input wire             pclk,
  input wire             presetn,
  // apb
  input wire [11:0]      paddr,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [31:0]      pwdata,
  input wire [31:0]      prdata,
  input wire             pready,
  input wire             pslverr,
  // pins, link, strobes and events
  input wire [NPIN-1:0]  pin_in,
  input wire [NPIN-1:0]  pin_out,
  input wire [NPIN-1:0]  pin_oe,
  input wire [NPIN-1:0]  pin_pd_en,
  input wire             link_en,
  input wire [NPORT-1:0] strobe_in,
  input wire [NPORT-1:0] strobe_out,
  input wire [NPORT-1:0] port_event
);
  // ============================================================
  // decode; register 7 of each port slot is a hole
  wire            acc     = psel && penable;
  wire            in_port = (paddr[11:8] == 4'h0) && (paddr[7:5] < 3'h6) && (paddr[1:0] == 2'h0);
  wire [NPIN-1:0] lpins   = LINK_MASK[NPIN-1:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ============================================================
  // bus answers
  chk_ready_high: assert property (acc |-> pready)
    else $error("pready low in access phase");
  chk_err_phase: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  chk_err_hole: assert property (acc && in_port && paddr[4:2] == 3'h7 |-> pslverr)
    else $error("hole address not refused");
  chk_err_mapped: assert property (acc && in_port && paddr[4:2] != 3'h7 |-> !pslverr)
    else $error("mapped address refused");
  chk_rdata_hold: assert property (acc ##1 !psel |-> $stable(prdata))
    else $error("read data moved after access");

  // ============================================================
  // pins: the link needs a cycle since output enables are registered
  chk_link_free: assert property (link_en && $past(link_en) |-> (pin_oe & lpins) == '0)
    else $error("port drives a link pin");
  chk_pd_off: assert property (pin_pd_en == '0)
    else $error("pull-down on outside reset");
  chk_quiet_release: assert property ($rose(presetn) |-> pin_oe == '0 && strobe_out == '0 && port_event == '0)
    else $error("outputs busy at reset release");

  // main scenarios
  cover property (acc && pslverr);
  cover property (link_en && |pin_oe);
  cover property (|port_event);
  cover property (|strobe_out);
endmodule // iop_chk

bind iop_top iop_chk #(.NPIN(NPIN), .NPORT(NPORT), .NCLK(NCLK), .LINK_MASK(LINK_MASK)) chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pd_en(pin_pd_en), .link_en(link_en),
  .strobe_in(strobe_in), .strobe_out(strobe_out), .port_event(port_event));

// ===== verif/io_port_clock_blocks_test.sv
// self-checking bench for the i/o port and clock block unit
`timescale 1ns/1ps
module io_port_clock_blocks_test;
  // ============================================================
  // stimulus, wires and score
  typedef struct { bit w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e; } iop_row_t;
  localparam [31:0] Z = 32'h0000_0000;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, link_en = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = Z, ext_val = Z, ext_en = 32'hFFFF_FFFF, rd;
  reg  [5:0]  stb_req = 6'h00;
  reg  [15:0] t0;
  reg  [7:0]  hist [0:19];
  reg         er;
  wire [31:0] prdata, pin_in, pin_out, pin_oe, pin_pd_en;
  wire [5:0]  strobe_in, strobe_out, port_event;
  wire        pready, pslverr;
  integer     n_mismatch = 0, num_checks = 0, cyc = 0, i, j, n0, s0;
  integer     ev_cnt [0:5] = '{default: 0};
  integer     st_cnt [0:5] = '{default: 0};
  iop_row_t   rows [0:10] = '{'{1'b0, 12'h040, Z, Z, 1'b0}, '{1'b0, 12'h0A0, Z, Z, 1'b0},
    '{1'b1, 12'h02C, 32'h0000_1234, Z, 1'b0}, '{1'b0, 12'h02C, Z, 32'h0000_1234, 1'b0},
    '{1'b1, 12'h100, 32'h0000_0101, Z, 1'b0}, '{1'b0, 12'h100, Z, Z, 1'b0},
    '{1'b1, 12'h104, 32'h0000_0301, Z, 1'b0}, '{1'b0, 12'h104, Z, 32'h0000_0301, 1'b0},
    '{1'b1, 12'h104, Z, Z, 1'b0}, '{1'b0, 12'h01C, Z, Z, 1'b1}, '{1'b1, 12'h0BC, Z, Z, 1'b1}};

  // ============================================================
  // design, pin-side hardware and clock
  iop_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pd_en(pin_pd_en), .link_en(link_en),
    .strobe_in(strobe_in), .strobe_out(strobe_out), .port_event(port_event));
  iop_ext_hw ext_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .ext_val(ext_val), .ext_en(ext_en), .stb_req(stb_req), .strobe_in(strobe_in));
  always #4 pclk = ~pclk;

  // pulse tallies, non-blocking so readers at the same edge see the old count; a run needs ~500 cycles
  always @(posedge pclk)
  begin
    for (int q = 0; q < 6; q++)
    begin
      ev_cnt[q] <= ev_cnt[q] + (port_event[q] === 1'b1);
      st_cnt[q] <= st_cnt[q] + (strobe_out[q] === 1'b1);
    end
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end

  // ============================================================
  // tasks
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // one apb transfer, entered just after an edge; the hold lasts until pready is sampled
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task wait_ev(input integer p);
    begin
      j = 0;
      while (ev_cnt[p] == n0 && j < 300)
      begin
        @(posedge pclk);
        j = j + 1;
      end
    end
  endtask

  task tally_and_finish;
    begin
      if (n_mismatch == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // ============================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    check("pd in reset", pin_pd_en, 32'hFFFF_FFFF);
    check("oe in reset", pin_oe, Z);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 11; i = i + 1)
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check("row data", rd & {32{~rows[i].w}}, rows[i].q);
      check("row err", er, rows[i].e);
    end
    // output walk: nibbles leave lowest first, one strobe per slice
    apb(1'b1, 12'h040, 32'h0000_0083);
    n0 = ev_cnt[2];
    s0 = st_cnt[2];
    apb(1'b1, 12'h044, 32'h8765_4321);
    for (i = 0; i < 20; i = i + 1)
    begin
      hist[i] = {pin_oe[3:0], pin_out[3:0]};
      @(posedge pclk);
    end
    j = 0;
    for (i = 19; i >= 0; i = i - 1)
      if (hist[i] == 8'hF1)
        j = i;
    for (i = 0; i < 8; i = i + 1)
      check("slice", hist[j + i], {4'hF, i[3:0] + 4'h1});
    check("load event", ev_cnt[2] - n0, 1);
    check("strobes", st_cnt[2] - s0, 8);
    // back-to-back count reads sit three ticks apart
    apb(1'b0, 12'h050, Z);
    t0 = rd[15:0];
    apb(1'b0, 12'h050, Z);
    check("count step", {16'h0000, rd[15:0] - t0}, 3);
    // a timed word leaves when the count meets the time register value
    apb(1'b1, 12'h040, 32'h0000_0023);
    apb(1'b0, 12'h050, Z);
    t0 = rd[15:0] + 16'h0040;
    apb(1'b1, 12'h04C, {16'h0000, t0});
    n0 = ev_cnt[2];
    apb(1'b1, 12'h044, 32'h1111_1111);
    wait_ev(2);
    check("timed wait", j > 40 && j < 80, 1);
    apb(1'b0, 12'h054, Z);
    check("timestamp", rd, {16'h0000, t0});
    // port3 input gathers four bytes into one word
    apb(1'b1, 12'h040, Z);
    ext_val <= 32'h0000_00A5;
    n0 = ev_cnt[3];
    apb(1'b1, 12'h060, 32'h0000_0001);
    wait_ev(3);
    apb(1'b0, 12'h078, Z);
    check("full flag", rd[0], 1);
    apb(1'b0, 12'h064, Z);
    check("in word", rd, 32'hA5A5_A5A5);
    // strobe in use: nothing is sampled until the far side strobes
    apb(1'b1, 12'h060, 32'h0000_0041);
    repeat (5) @(posedge pclk);
    n0 = ev_cnt[3];
    repeat (60) @(posedge pclk);
    check("no strobe", ev_cnt[3] - n0, 0);
    stb_req <= 6'h08;
    wait_ev(3);
    check("strobed", j < 300, 1);
    // port0 waits for its pin to equal the compare value
    ext_val <= Z;
    apb(1'b1, 12'h008, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0009);
    n0 = ev_cnt[0];
    repeat (60) @(posedge pclk);
    check("cond held", ev_cnt[0] - n0, 0);
    ext_val <= 32'h0000_0001;
    wait_ev(0);
    apb(1'b0, 12'h004, Z);
    check("cond word", rd, 32'hFFFF_FFFF);
    // narrow ports own shared pins, the link takes the top four
    stb_req <= 6'h00;
    apb(1'b1, 12'h000, Z);
    apb(1'b1, 12'h040, 32'h0000_0001);
    apb(1'b1, 12'h060, 32'h0000_0003);
    apb(1'b1, 12'h0A0, 32'h0000_0003);
    apb(1'b1, 12'h064, 32'hFFFF_FFFF);
    apb(1'b1, 12'h0A4, 32'hFFFF_FFFF);
    repeat (20) @(posedge pclk);
    check("shared oe", pin_oe, 32'hFFFF_FFF0);
    check("shared out", pin_out | 32'h0000_000F, 32'hFFFF_FFFF);
    link_en <= 1'b1;
    repeat (3) @(posedge pclk);
    check("link oe", pin_oe, 32'h0FFF_FFF0);
    link_en <= 1'b0;
    // open drain: zeros pull low, ones float to the board pull-up
    apb(1'b1, 12'h060, Z);
    apb(1'b1, 12'h0A0, Z);
    ext_en <= 32'hFFFF_FFF0;
    apb(1'b1, 12'h040, 32'h0000_0007);
    apb(1'b1, 12'h044, 32'h5555_5555);
    repeat (20) @(posedge pclk);
    check("od pins", {pin_oe[3:0], pin_out[3:0], pin_in[3:0]}, 32'h0000_0A05);
    // block 1 ticks on every second rising edge of pin1; our driver must own pin1 again
    ext_en <= 32'hFFFF_FFFF;
    apb(1'b1, 12'h040, Z);
    apb(1'b1, 12'h104, 32'h0000_0103);
    apb(1'b1, 12'h060, 32'h0000_0101);
    apb(1'b0, 12'h070, Z);
    t0 = rd[15:0];
    for (i = 0; i < 16; i = i + 1)
    begin
      ext_val[1] <= ~ext_val[1];
      repeat (3) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    apb(1'b0, 12'h070, Z);
    check("pin clock", {16'h0000, rd[15:0] - t0}, 4);
    // reset in mid-run: pull-downs on, drive off, ports back on block 0
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("pd mid reset", pin_pd_en, 32'hFFFF_FFFF);
    check("oe mid reset", pin_oe, Z);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h060, Z);
    check("ctrl after reset", rd, Z);
    apb(1'b0, 12'h104, Z);
    check("clk after reset", rd, Z);
    tally_and_finish;
  end
endmodule // io_port_clock_blocks_test
